// ---- common/dispmem_defines.vh ----
`ifndef DISPMEM_DEFINES_VH
`define DISPMEM_DEFINES_VH
// organization codes
`define ORG_PLANAR 1'b0
`define ORG_LINEAR 1'b1
// write types
`define WMODE_0 2'h0
`define WMODE_1 2'h1
`define WMODE_2 2'h2
`define WMODE_3 2'h3
// refresh modes
`define RMODE_WORD 1'b0
`define RMODE_BYTE 1'b1
// reset values
`define SEG_RESET 8'h00
`define PLANE_MASK_RESET 4'hF
`define READ_SEL_RESET 2'h0
// plane enables
`define PLANES_ALL 4'hF
`define REF_PLANES_TEXT 4'hC
`define REF_PLANES_GFX 4'hF
// address widths
`define CPU_AW 22
`define MEM_AW 20
`endif

// ---- design/plane_alu.v ----
// Purpose: planar write datapath, one lane per plane
// Assumes: latches hold last read data per plane
// Notes: set/reset, bit mask and write types
`include "dispmem_defines.vh"

module plane_alu (
  // control
  input wire [1:0] write_type,
  input wire [3:0] set_reset,
  input wire [3:0] set_reset_en,
  input wire [7:0] bit_mask,
  // data
  input wire [7:0] cpu_byte,
  input wire [31:0] latches,
  output wire [31:0] wdata
);
  genvar p;
  generate
    for (p = 0; p < 4; p = p + 1) begin : lane
      wire [7:0] srv;
      wire [7:0] src;
      wire [7:0] msk;
      assign srv = {8{set_reset[p]}};
      assign src = (write_type == `WMODE_2) ? srv :
                   (set_reset_en[p] ? srv : cpu_byte);
      // bit mask picks which of the 8 pixels one access touches
      assign msk = (write_type == `WMODE_3) ? (bit_mask & cpu_byte) : bit_mask;
      assign wdata[p*8+7:p*8] = (write_type == `WMODE_1) ? latches[p*8+7:p*8] :
                                ((src & msk) | (latches[p*8+7:p*8] & ~msk));
    end
  endgenerate
endmodule // plane_alu

// ---- design/color_compare.v ----
// Purpose: read type 1 colour compare over four planes
// Assumes: latches carry one byte per plane
// Notes: care bits drop planes from the compare
module color_compare (
  // inputs
  input wire [31:0] latches,
  input wire [3:0] cmp_color,
  input wire [3:0] cmp_care,
  // result
  output wire [7:0] match
);
  genvar b;
  generate
    for (b = 0; b < 8; b = b + 1) begin : pix
      wire [3:0] pv;
      assign pv = {latches[24+b], latches[16+b], latches[8+b], latches[b]};
      assign match[b] = &(~((pv ^ cmp_color) & cmp_care));
    end
  endgenerate
endmodule // color_compare

// ---- design/display_memory_addressing.v ----
// Purpose: map cpu and refresh accesses onto four-plane display memory
// Assumes: one access per request pulse; memory answers next cycle
// Notes: translator offset supplied as a plain port
`include "dispmem_defines.vh"

module display_memory_addressing (
  // clock and reset
  input wire clk,
  input wire rst,
  // configuration
  input wire linear_mode,
  input wire text_mode,
  input wire translator_en,
  input wire [7:0] translator_base,
  input wire [1:0] read_plane_selector,
  input wire [3:0] write_plane_mask,
  input wire read_type,
  input wire [1:0] write_type,
  input wire [3:0] set_reset,
  input wire [3:0] set_reset_en,
  input wire [7:0] bit_mask,
  input wire [3:0] cmp_color,
  input wire [3:0] cmp_care,
  // segment pointer access
  input wire seg_we,
  input wire [7:0] seg_wdata,
  output reg [7:0] segment_pointer,
  // cpu side
  input wire cpu_req,
  input wire cpu_we,
  input wire [21:0] cpu_addr,
  input wire [7:0] cpu_wdata,
  output reg [7:0] cpu_rdata,
  output reg cpu_ack,
  // refresh side
  input wire ref_req,
  input wire refresh_mode,
  input wire [19:0] linear_count,
  input wire [4:0] char_row_scan,
  input wire [7:0] char_code,
  input wire [2:0] font_select,
  output reg [3:0] ref_planes,
  // video memory
  output reg mem_req,
  output reg mem_we,
  output reg [19:0] video_dword_address,
  output reg [3:0] mem_plane_en,
  output reg [31:0] mem_wdata,
  input wire [31:0] mem_rdata
);
  // ************************************************************
  // address formation
  // ************************************************************
  reg [31:0] latches;
  // one-bit machine: idle, or a cpu read waiting for its data
  localparam ST_IDLE = 1'b0;
  localparam ST_READ = 1'b1;
  reg state;
  reg next_state;
  reg take_ref;
  reg take_cpu;
  reg [7:0] next_segment_pointer;
  reg [7:0] next_cpu_rdata;
  reg next_cpu_ack;
  reg [3:0] next_ref_planes;
  reg next_mem_req;
  reg next_mem_we;
  reg [19:0] next_video_dword_address;
  reg [3:0] next_mem_plane_en;
  reg [31:0] next_mem_wdata;
  reg [31:0] next_latches;
  reg [1:0] next_pend_lane;
  reg next_pend_linear;
  reg [1:0] pend_lane;
  reg pend_linear;
  wire [31:0] alu_wdata;
  wire [7:0] cmp_match;
  reg [19:0] next_cpu_ma;
  reg [3:0] next_cpu_planes;
  reg [19:0] next_ref_ma;
  reg [1:0] lane;

  always @* begin
    lane = cpu_addr[1:0];
    next_cpu_planes = 4'h0;
    if (linear_mode == `ORG_PLANAR) begin
      next_cpu_ma = {segment_pointer[3:0], cpu_addr[15:0]};
      next_cpu_planes = cpu_we ? write_plane_mask : 4'hF;
    end else if (translator_en) begin
      next_cpu_ma = {translator_base[5:0], cpu_addr[15:2]};
      next_cpu_planes = 4'h1 << lane;
    end else begin
      next_cpu_ma = {segment_pointer[5:0], cpu_addr[15:2]};
      next_cpu_planes = 4'h1 << lane;
    end
  end

  // ************************************************************
  // refresh address
  // ************************************************************
  always @* begin
    if (text_mode) begin
      next_ref_ma = {4'h0, font_select[1], font_select[0], font_select[2], char_code, char_row_scan};
    end else if (refresh_mode == `RMODE_WORD) begin
      next_ref_ma = {linear_count[19:16], linear_count[14:0], linear_count[15]};
    end else begin
      next_ref_ma = linear_count;
    end
  end

  // ************************************************************
  // datapath
  // ************************************************************
  // four write types
  plane_alu u_alu (
    .write_type(write_type),
    .set_reset(set_reset),
    .set_reset_en(set_reset_en),
    .bit_mask(bit_mask),
    .cpu_byte(cpu_wdata),
    .latches(latches),
    .wdata(alu_wdata)
  );

  color_compare u_cmp (
    .latches(mem_rdata),
    .cmp_color(cmp_color),
    .cmp_care(cmp_care),
    .match(cmp_match)
  );

  // ************************************************************
  // request arbitration
  // ************************************************************
  // refresh has priority; a cpu request waits while ref_req is high
  // and is refused while a read is still waiting for its data
  always @* begin
    take_ref = ref_req;
    take_cpu = 1'b0;
    case (state)
      ST_IDLE: begin
        take_cpu = cpu_req && !ref_req;
      end
      ST_READ: begin
        take_cpu = 1'b0;
      end
      default: begin
        take_cpu = 1'b0;
      end
    endcase
  end

  always @* begin
    next_state = ST_IDLE;
    case (state)
      ST_IDLE: begin
        if (take_cpu && !cpu_we) begin
          next_state = ST_READ;
        end
      end
      ST_READ: begin
        next_state = ST_IDLE;
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  // ************************************************************
  // next values
  // ************************************************************
  // host writable pointer
  always @* begin
    next_segment_pointer = segment_pointer;
    if (seg_we) begin
      next_segment_pointer = seg_wdata;
    end
  end

  // read data comes back one cycle after the request
  always @* begin
    next_cpu_rdata = cpu_rdata;
    next_latches = latches;
    next_cpu_ack = 1'b0;
    if (state == ST_READ) begin
      next_latches = mem_rdata;
      next_cpu_ack = 1'b1;
      if (pend_linear) begin
        next_cpu_rdata = mem_rdata[{pend_lane, 3'b000} +: 8];
      end else if (read_type) begin
        next_cpu_rdata = cmp_match;
      end else begin
        next_cpu_rdata = mem_rdata[{read_plane_selector, 3'b000} +: 8];
      end
    end else if (take_cpu && cpu_we) begin
      // writes are acknowledged as they are issued
      next_cpu_ack = 1'b1;
    end
  end

  always @* begin
    next_mem_req = 1'b0;
    next_mem_we = 1'b0;
    next_video_dword_address = video_dword_address;
    next_mem_plane_en = mem_plane_en;
    next_mem_wdata = mem_wdata;
    next_ref_planes = ref_planes;
    next_pend_lane = pend_lane;
    next_pend_linear = pend_linear;
    if (take_ref) begin
      next_mem_req = 1'b1;
      next_video_dword_address = next_ref_ma;
      next_ref_planes = text_mode ? `REF_PLANES_TEXT : `REF_PLANES_GFX;
      next_mem_plane_en = `PLANES_ALL;
    end else if (take_cpu) begin
      next_mem_req = 1'b1;
      next_mem_we = cpu_we;
      next_video_dword_address = next_cpu_ma;
      next_mem_plane_en = next_cpu_planes;
      // linear writes copy the byte to every lane; the enable picks one
      next_mem_wdata = linear_mode ? {4{cpu_wdata}} : alu_wdata;
      next_pend_lane = lane;
      next_pend_linear = linear_mode;
    end
  end

  // ************************************************************
  // segment pointer
  // ************************************************************
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      segment_pointer <= `SEG_RESET;
    end else begin
      segment_pointer <= next_segment_pointer;
    end
  end

  // ************************************************************
  // cpu side registers
  // ************************************************************
  // latches load on cpu reads only, never on refresh fetches
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= ST_IDLE;
      cpu_rdata <= 8'h00;
      cpu_ack <= 1'b0;
      latches <= 32'h0000_0000;
      pend_lane <= 2'h0;
      pend_linear <= 1'b0;
    end else begin
      state <= next_state;
      cpu_rdata <= next_cpu_rdata;
      cpu_ack <= next_cpu_ack;
      latches <= next_latches;
      pend_lane <= next_pend_lane;
      pend_linear <= next_pend_linear;
    end
  end

  // ************************************************************
  // memory side registers
  // ************************************************************
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      ref_planes <= 4'h0;
      mem_req <= 1'b0;
      mem_we <= 1'b0;
      video_dword_address <= 20'h0_0000;
      mem_plane_en <= 4'h0;
      mem_wdata <= 32'h0000_0000;
    end else begin
      ref_planes <= next_ref_planes;
      mem_req <= next_mem_req;
      mem_we <= next_mem_we;
      video_dword_address <= next_video_dword_address;
      mem_plane_en <= next_mem_plane_en;
      mem_wdata <= next_mem_wdata;
    end
  end
endmodule // display_memory_addressing

// ---- dv/dispmem_monitor.sv ----
// Purpose: port checks for display memory addressing
// Assumes: plane n sits in byte lane n
// Notes: a refresh take never meets a cpu take
module dispmem_monitor (
  // clock and reset
  input wire clk,
  input wire rst,
  // watched ports
  input wire linear_mode,
  input wire translator_en,
  input wire [7:0] translator_base,
  input wire [3:0] write_plane_mask,
  input wire seg_we,
  input wire [7:0] seg_wdata,
  input wire [7:0] segment_pointer,
  input wire cpu_req,
  input wire [21:0] cpu_addr,
  input wire cpu_ack,
  input wire ref_req,
  input wire mem_req,
  input wire mem_we,
  input wire [19:0] video_dword_address,
  input wire [3:0] mem_plane_en
);
  timeunit 1ns;
  timeprecision 1ns;
  // ****
  // checks
  // ****
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence p_go; cpu_req && !ref_req && !linear_mode ##1 mem_req; endsequence
  sequence l_go; cpu_req && !ref_req && linear_mode ##1 mem_req; endsequence
  seg_load_a: assert property (seg_we |=> segment_pointer == $past(seg_wdata))
    else $error("segment not loaded");
  planar_addr_a: assert property (p_go |->
    video_dword_address == {$past(segment_pointer[3:0]), $past(cpu_addr[15:0])}) else $error("planar address");
  linear_addr_a: assert property (l_go |-> video_dword_address[13:0] == $past(cpu_addr[15:2]) &&
    video_dword_address[19:14] == ($past(translator_en) ? $past(translator_base[5:0]) : $past(segment_pointer[5:0])))
    else $error("linear address");
  lane_pick_a: assert property (l_go ##0 mem_we |-> mem_plane_en == 4'h1 << $past(cpu_addr[1:0]))
    else $error("linear lane");
  write_mask_a: assert property (p_go ##0 mem_we |-> mem_plane_en == $past(write_plane_mask))
    else $error("write mask");
  all_planes_a: assert property (p_go ##0 !mem_we |-> mem_plane_en == 4'hF)
    else $error("planar read planes");
  write_ack_a: assert property (mem_req && mem_we |-> cpu_ack)
    else $error("write ack");
  read_ack_a: assert property (mem_req && !mem_we && $past(cpu_req) && !$past(ref_req) |=> cpu_ack)
    else $error("read ack");
endmodule // dispmem_monitor
bind display_memory_addressing dispmem_monitor u_dispmem_monitor (.*);

// ---- dv/vmem_model.sv ----
// Purpose: four-lane video memory
// Assumes: read data in the same cycle as mem_req
// Notes: only 256 dwords, upper address aliases
module vmem_model (
  // clock
  input wire logic clk,
  // memory port
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [19:0] video_dword_address,
  input wire logic [3:0] mem_plane_en,
  input wire logic [31:0] mem_wdata,
  output logic [31:0] mem_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [31:0] ram [256] = '{default: 32'h0000_0000};
  logic [31:0] idle_word = 32'h0000_0000;
  // read data stands while the request does, so it is there at the next edge
  // idle data toggles so stale values never match
  assign mem_rdata = (mem_req && !mem_we) ? ram[video_dword_address[7:0]] : idle_word;
  always @(posedge clk) begin
    idle_word <= ~idle_word;
    for (int i = 0; i < 4; i++)
      if (mem_req && mem_we && mem_plane_en[i])
        ram[video_dword_address[7:0]][8*i +: 8] <= mem_wdata[8*i +: 8];
  end
endmodule // vmem_model

// ---- dv/testbench.sv ----
// Purpose: self-checking bench
// Assumes: inputs move 2 ns after each edge
// Notes: every access is queued, acks pop them
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, rst = 1, linear_mode = 0, text_mode = 0, translator_en = 0, read_type = 0, seg_we = 0;
  logic cpu_req = 0, cpu_we = 0, ref_req = 0, refresh_mode = 0, cpu_ack, mem_req, mem_we;
  logic [1:0] read_plane_selector = '0, write_type = '0;
  logic [2:0] font_select = '0;
  logic [3:0] write_plane_mask = '0, set_reset = '0, set_reset_en = '0, cmp_color = '0, cmp_care = '0;
  logic [3:0] ref_planes, mem_plane_en;
  logic [4:0] char_row_scan = '0;
  logic [7:0] translator_base = '0, bit_mask = 8'hFF, seg_wdata = '0, cpu_wdata = '0, char_code = '0;
  logic [7:0] segment_pointer, cpu_rdata, d, m;
  logic [19:0] linear_count = '0, video_dword_address;
  logic [21:0] cpu_addr = '0;
  logic [31:0] mem_wdata, mem_rdata;
  logic [8:0] q [$];
  logic [8:0] n;
  logic [63:0] r;
  int num_errors = 0, tests_run = 0, cycles = 0;
  integer seed = 32'h862a;
  always #25 clk = ~clk;
  display_memory_addressing u_display_memory_addressing (.*);
  vmem_model u_vmem_model (.*);
  task check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task give_verdict;
    $display("compares %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task access(input logic we, input logic [21:0] a, input logic [7:0] wd, input logic [7:0] e);
    q.push_back({~we, e});
    cpu_we = we;
    cpu_addr = a;
    cpu_wdata = wd;
    cpu_req = 1;
    // hold the request until the acknowledge stands, then drop it
    do @(posedge clk) #2; while (cpu_ack !== 1'b1);
    cpu_req = 0;
    @(posedge clk) #2;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      num_errors++;
      give_verdict;
    end
  end
  always @(posedge clk)
    if (cpu_ack === 1'b1) begin
      n = q.pop_front();
      if (n[8]) check(cpu_rdata, n[7:0]);
    end
  initial begin
    r = {$random(seed), $random(seed)};
    {set_reset, cmp_color, cmp_care, linear_count, char_row_scan, char_code, font_select, translator_base} = r[55:0];
    repeat (5) @(posedge clk);
    #2 rst = 0;
    check(segment_pointer, 8'h00);
    d = $random(seed);
    seg_we = 1;
    seg_wdata = d;
    @(posedge clk) #2 seg_we = 0;
    check(segment_pointer, d);
    $display("segment test done");
    // planar: mask on write, select on read
    for (int i = 0; i < 4; i++) begin
      d = $random(seed);
      m = $random(seed);
      write_plane_mask = m[3:0];
      access(1, 22'h0010 + i, d, 8'h00);
      for (int s = 0; s < 4; s++) begin
        read_plane_selector = s[1:0];
        access(0, 22'h0010 + i, 8'h00, m[s] ? d : 8'h00);
      end
    end
    // type 2 fills from set/reset, colour compare reads it back
    write_plane_mask = 4'hF;
    write_type = 2'h2;
    access(1, 22'h0020, 8'h00, 8'h00);
    read_type = 1;
    cmp_color = set_reset;
    cmp_care = 4'hF;
    access(0, 22'h0020, 8'h00, 8'hFF);
    cmp_color = ~set_reset;
    access(0, 22'h0020, 8'h00, 8'h00);
    // type 1 copies the latches, type 3 masks set/reset with the cpu byte
    write_type = 2'h1;
    access(1, 22'h0021, d, 8'h00);
    read_type = 0;
    read_plane_selector = 2'h0;
    access(0, 22'h0021, 8'h00, {8{set_reset[0]}});
    set_reset = ~set_reset;
    set_reset_en = 4'hF;
    write_type = 2'h3;
    access(1, 22'h0022, d, 8'h00);
    write_type = 2'h0;
    set_reset_en = 4'h0;
    access(0, 22'h0022, 8'h00, {8{~set_reset[0]}} ^ d);
    $display("planar test done");
    // linear: mask is ignored, lanes chained
    linear_mode = 1;
    write_plane_mask = 4'h0;
    for (int t = 0; t < 4; t++) begin
      translator_en = t[1];
      d = $random(seed);
      access(1, 22'h0040 + t, d, 8'h00);
      access(0, 22'h0040 + t, 8'h00, d);
    end
    $display("linear test done");
    for (int x = 0; x < 3; x++) begin
      text_mode = (x == 1);
      refresh_mode = (x != 0);
      ref_req = 1;
      @(posedge clk) #2 ref_req = 0;
      check({28'h000_0000, ref_planes}, (x == 1) ? 32'h0000_000C : 32'h0000_000F);
      case (x)
        0: check(video_dword_address, {linear_count[19:16], linear_count[14:0], linear_count[15]});
        1: check(video_dword_address, {font_select[1], font_select[0], font_select[2], char_code, char_row_scan});
        default: check(video_dword_address, linear_count);
      endcase
    end
    $display("refresh test done");
    check({7'h00, q.size() == 0}, 8'h01);
    give_verdict;
  end
endmodule // testbench
